//--- rtl/trig_seq_pkg.sv
// Constants, field layouts and carrier types for the external trigger scan sequencer.
// Function
// (R1) One conversion per falling strobe edge.
// (R2) Channels ascend from start through end.
// (R3) Interval timer ignored; strobes set spacing.
// (R4) Software clears control bit 2 first.
// (R5) Source waits settling time before strobing.
// (R6) Strobe moves previous result to mailbox.
// (R7) One extra strobe flushes last result.
// (R8) First strobe after arming writes nothing.
// (R9) Software arms before the first strobe.
// (R10) Start-convert bit only arms, never converts.
// (R11) Differential passes alternate mailbox halves.
// (R12) Halves at words 40h-5Eh and 60h-7Fh.
// (R13) Channel interrupt 8 us after strobe.
// (R14) No channel interrupt on first strobe.
// (R15) Group interrupt 8 us after group flush.
// (R16) Master module drives trigger as output.
// (R17) Slaves trigger-only; master start begins group.
// (R18) Writing zero scan mode stops scanning.
// (R19) Channel pointer wraps end to start.
// (R20) Strobe synchronised; edges ignored unless armed.
package trig_seq_pkg;
	// Register byte addresses on the AXI4-Lite bus.
	localparam logic [4:0] ADDR_CTRL    = 5'h00;
	localparam logic [4:0] ADDR_START   = 5'h04;
	localparam logic [4:0] ADDR_END     = 5'h08;
	localparam logic [4:0] ADDR_ARM     = 5'h0C;
	localparam logic [4:0] ADDR_STATUS  = 5'h10;
	// Control register field positions.
	localparam int CTRL_DIR_BIT    = 2;
	localparam int CTRL_MODE_LSB   = 8;
	localparam int CTRL_DIFF_BIT   = 11;
	localparam int CTRL_INT_LSB    = 12;
	// Scan mode codes; reset loads the stop code, so trigger-only must be written.
	localparam logic [2:0] MODE_STOP      = 3'h0;
	localparam logic [2:0] MODE_TRIG_ONLY = 3'h5;
	// Interrupt mode codes.
	localparam logic [1:0] INT_NONE    = 2'h0;
	localparam logic [1:0] INT_CHANNEL = 2'h1;
	localparam logic [1:0] INT_GROUP   = 2'h2;
	// Mailbox word address bases of the two halves.
	localparam logic [6:0] MB_BASE_LO  = 7'h40;
	localparam logic [6:0] MB_BASE_HI  = 7'h60;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Interrupt delay after a strobe.
	localparam int CLK_MHZ       = 200;
	localparam int IRQ_DELAY_US  = 8;
	localparam int IRQ_CYCLES    = IRQ_DELAY_US * CLK_MHZ;
	localparam logic [10:0] IRQ_COUNT = 11'(IRQ_CYCLES);
	// Control register contents.
	typedef struct packed {
		logic [1:0] int_mode;
		logic       diff;
		logic [2:0] scan_mode;
		logic       strobe_dir;
	} ctrl_t;
	// One write into the mailbox buffer.
	typedef struct packed {
		logic        we;
		logic [6:0]  addr;
		logic [15:0] data;
	} mb_wr_t;
	// Sequencer states, one-hot.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_PRIME = 3'b010,
		ST_RUN   = 3'b100
	} seq_state_t;
endpackage : trig_seq_pkg

//--- rtl/trig_seq.sv
// External trigger scan sequencer with AXI4-Lite register access.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module trig_seq
(
	input  wire logic                 aclk,              // Module clock, 200 MHz.
	input  wire logic                 aresetn,           // Synchronous reset, active low.
	input  wire logic [4:0]           s_axi_awaddr,      // Write address.
	input  wire logic                 s_axi_awvalid,     // Write address valid.
	output logic                      s_axi_awready,     // Write address ready.
	input  wire logic [31:0]          s_axi_wdata,       // Write data.
	input  wire logic [3:0]           s_axi_wstrb,       // Write byte strobes.
	input  wire logic                 s_axi_wvalid,      // Write data valid.
	output logic                      s_axi_wready,      // Write data ready.
	output logic [1:0]                s_axi_bresp,       // Write response.
	output logic                      s_axi_bvalid,      // Write response valid.
	input  wire logic                 s_axi_bready,      // Write response ready.
	input  wire logic [4:0]           s_axi_araddr,      // Read address.
	input  wire logic                 s_axi_arvalid,     // Read address valid.
	output logic                      s_axi_arready,     // Read address ready.
	output logic [31:0]               s_axi_rdata,       // Read data.
	output logic [1:0]                s_axi_rresp,       // Read response.
	output logic                      s_axi_rvalid,      // Read data valid.
	input  wire logic                 s_axi_rready,      // Read data ready.
	input  wire logic                 conversion_strobe_n, // Trigger pin input, active low.
	output logic                      strobe_out,        // Trigger pin output level.
	output logic                      strobe_oe,         // Trigger pin output enable.
	input  wire logic [15:0]          adc_result,        // Converter result of the last conversion.
	output logic                      conv_start,        // One-cycle conversion start pulse.
	output logic [4:0]                conv_channel,      // Channel being converted.
	output trig_seq_pkg::mb_wr_t      mb_wr,             // Mailbox write port.
	output logic                      irq                // Interrupt request, level.
);

	// Register state.
	trig_seq_pkg::ctrl_t      ctrl;           // Control register.
	logic [4:0]               start_ch;       // First channel of a pass.
	logic [4:0]               end_ch;         // Last channel of a pass.
	trig_seq_pkg::seq_state_t state;          // Sequencer state.
	logic [4:0]               ptr;            // Next channel to convert.
	logic [4:0]               prev_ch;        // Channel held in the converter.
	logic                     half;           // Half for the pass of the next channel to convert.
	logic                     prev_half;      // Half for the result held in the converter.
	logic                     group_wait;     // End channel held; next strobe flushes group.
	logic [10:0]              timer;          // Interrupt delay counter, zero when idle.
	logic                     sync1;          // First synchroniser stage.
	logic                     sync2;          // Second synchroniser stage.
	logic                     sync3;          // Previous synchronised level.
	logic                     strobe_fall;    // Falling edge seen on the strobe.

	// Bus bookkeeping.
	logic                     aw_held;        // Write address captured.
	logic                     w_held;         // Write data captured.
	logic [4:0]               aw_addr;        // Captured write address.
	logic [31:0]              w_data;         // Captured write data.
	logic [3:0]               w_strb;         // Captured byte strobes.
	logic                     do_write;       // Both halves present; commit the write.
	logic                     wr_hit;         // Write address is mapped.
	logic                     arm_write;      // Software wrote one to the arm bit.
	logic                     irq_clear;      // Software cleared the interrupt flag.
	logic                     mode_active;    // Trigger-only mode selected.
	logic                     step;           // Strobe accepted this cycle.
	logic [6:0]               next_addr;      // Mailbox address for the held result.

	assign do_write    = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit      = (aw_addr == trig_seq_pkg::ADDR_CTRL) || (aw_addr == trig_seq_pkg::ADDR_START)
	                  || (aw_addr == trig_seq_pkg::ADDR_END) || (aw_addr == trig_seq_pkg::ADDR_ARM)
	                  || (aw_addr == trig_seq_pkg::ADDR_STATUS);
	assign arm_write   = do_write && (aw_addr == trig_seq_pkg::ADDR_ARM) && w_strb[0] && w_data[0];
	assign irq_clear   = do_write && (aw_addr == trig_seq_pkg::ADDR_STATUS) && w_strb[0] && w_data[0];
	assign mode_active = (ctrl.scan_mode == trig_seq_pkg::MODE_TRIG_ONLY);
	// Only an armed sequencer in trigger-only mode reacts to a strobe edge. [R20] [R3]
	assign step        = strobe_fall && mode_active && (state != trig_seq_pkg::ST_IDLE);
	// Each half holds channels at a two-word step; the second half only in differential use. [R12]
	assign next_addr   = (prev_half ? trig_seq_pkg::MB_BASE_HI : trig_seq_pkg::MB_BASE_LO)
	                   + {1'b0, prev_ch, 1'b0};

	// The pin never leaves the synchroniser chain unsampled: the first stage feeds only
	// the second, so metastability cannot reach the edge detector. [R20]
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1       <= 1'b1;
			sync2       <= 1'b1;
			sync3       <= 1'b1;
			strobe_fall <= 1'b0;
		end
		else
		begin
			sync1       <= conversion_strobe_n;
			sync2       <= sync1;
			sync3       <= sync2;
			strobe_fall <= sync3 && !sync2;   // One pulse per falling edge. [R1] [R20]
		end
	end

	// Write address and data channels are captured independently, in either order.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 5'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= trig_seq_pkg::RESP_OKAY;
		end
		else
		begin
			// Capture the address when offered.
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			// Capture the data when offered.
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// Commit and answer; unmapped addresses get SLVERR.
			if (do_write)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? trig_seq_pkg::RESP_OKAY : trig_seq_pkg::RESP_SLVERR;
			end
			// Reopen both channels once the response is taken.
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Configuration registers. Writing zero into the scan mode stops the scanner. [R18]
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl     <= '0;
			start_ch <= 5'h00;
			end_ch   <= 5'h00;
		end
		else if (do_write)
		begin
			// Control bits sit in bytes 0 and 1.
			if (aw_addr == trig_seq_pkg::ADDR_CTRL)
			begin
				if (w_strb[0])
				begin
					ctrl.strobe_dir <= w_data[trig_seq_pkg::CTRL_DIR_BIT];
				end
				if (w_strb[1])
				begin
					ctrl.scan_mode <= w_data[trig_seq_pkg::CTRL_MODE_LSB +: 3];
					ctrl.diff      <= w_data[trig_seq_pkg::CTRL_DIFF_BIT];
					ctrl.int_mode  <= w_data[trig_seq_pkg::CTRL_INT_LSB +: 2];
				end
			end
			// Channel limits sit in byte 0.
			if ((aw_addr == trig_seq_pkg::ADDR_START) && w_strb[0])
			begin
				start_ch <= w_data[4:0];
			end
			if ((aw_addr == trig_seq_pkg::ADDR_END) && w_strb[0])
			begin
				end_ch <= w_data[4:0];
			end
		end
	end

	// Trigger pin direction follows control bit 2; in this mode software keeps it low,
	// so the pin stays an input and the driven level is only a parked high. [R4]
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			strobe_oe  <= 1'b0;
			strobe_out <= 1'b1;
		end
		else
		begin
			strobe_oe  <= ctrl.strobe_dir;
			strobe_out <= 1'b1;
		end
	end

	// Read channel: one read at a time, answered the cycle after the address is taken.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= trig_seq_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= trig_seq_pkg::RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			case (s_axi_araddr)
				trig_seq_pkg::ADDR_CTRL:
				begin
					s_axi_rdata[trig_seq_pkg::CTRL_DIR_BIT]        <= ctrl.strobe_dir;
					s_axi_rdata[trig_seq_pkg::CTRL_MODE_LSB +: 3]  <= ctrl.scan_mode;
					s_axi_rdata[trig_seq_pkg::CTRL_DIFF_BIT]       <= ctrl.diff;
					s_axi_rdata[trig_seq_pkg::CTRL_INT_LSB +: 2]   <= ctrl.int_mode;
				end
				trig_seq_pkg::ADDR_START:
				begin
					s_axi_rdata[4:0] <= start_ch;
				end
				trig_seq_pkg::ADDR_END:
				begin
					s_axi_rdata[4:0] <= end_ch;
				end
				trig_seq_pkg::ADDR_ARM:
				begin
					s_axi_rdata[0] <= (state != trig_seq_pkg::ST_IDLE);
				end
				trig_seq_pkg::ADDR_STATUS:
				begin
					// Flag, priming, half, group wait and pointer of the live sequencer.
					s_axi_rdata[0]    <= irq;
					s_axi_rdata[1]    <= (state == trig_seq_pkg::ST_PRIME);
					s_axi_rdata[2]    <= half;
					s_axi_rdata[3]    <= group_wait;
					s_axi_rdata[12:8] <= ptr;
				end
				default:
				begin
					s_axi_rresp <= trig_seq_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Sequencer state. The arm write only arms; conversions come from strobes alone. [R10]
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= trig_seq_pkg::ST_IDLE;
		end
		else
		begin
			case (state)
				trig_seq_pkg::ST_IDLE:
				begin
					if (arm_write && mode_active)
					begin
						state <= trig_seq_pkg::ST_PRIME;
					end
				end
				trig_seq_pkg::ST_PRIME:
				begin
					if (!mode_active)
					begin
						state <= trig_seq_pkg::ST_IDLE;   // [R18]
					end
					else if (step)
					begin
						state <= trig_seq_pkg::ST_RUN;   // Converter now holds fresh data. [R8]
					end
				end
				trig_seq_pkg::ST_RUN:
				begin
					if (!mode_active)
					begin
						state <= trig_seq_pkg::ST_IDLE;   // [R18]
					end
					else if (arm_write)
					begin
						state <= trig_seq_pkg::ST_PRIME;  // Re-arming restarts from the start channel.
					end
				end
				default:
				begin
					state <= trig_seq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Channel walk: convert the pointer on each strobe and wrap after the end channel.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ptr          <= 5'h00;
			prev_ch      <= 5'h00;
			half         <= 1'b0;
			prev_half    <= 1'b0;
			group_wait   <= 1'b0;
			conv_start   <= 1'b0;
			conv_channel <= 5'h00;
		end
		else
		begin
			conv_start <= step;   // [R1]
			if (arm_write || (state == trig_seq_pkg::ST_IDLE))
			begin
				// Each arming begins its pass at the start channel in the first half.
				ptr        <= start_ch;
				half       <= 1'b0;
				group_wait <= 1'b0;
			end
			else if (step)
			begin
				conv_channel <= ptr;
				prev_ch      <= ptr;
				prev_half    <= half;
				group_wait   <= (ptr == end_ch);
				if (ptr == end_ch)
				begin
					ptr  <= start_ch;           // [R19]
					half <= ctrl.diff && !half; // [R11]
				end
				else
				begin
					ptr <= ptr + 5'h01;         // [R2]
				end
			end
		end
	end

	// Mailbox write: each strobe while running moves the held result in, so the mailbox
	// trails the converter by one strobe and needs one extra strobe to flush. [R6] [R7]
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mb_wr <= '0;
		end
		else
		begin
			mb_wr.we <= step && (state == trig_seq_pkg::ST_RUN);   // [R8]
			if (step)
			begin
				mb_wr.addr <= next_addr;    // [R12]
				mb_wr.data <= adc_result;   // [R6]
			end
		end
	end

	// Interrupt delay: a new qualifying strobe restarts the count, which trades a lost
	// interrupt under strobes closer than the delay for a single, simple counter.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer <= 11'h000;
		end
		else if (step && (state == trig_seq_pkg::ST_RUN)
		         && (((ctrl.int_mode == trig_seq_pkg::INT_CHANNEL))             // [R13] [R14]
		         || ((ctrl.int_mode == trig_seq_pkg::INT_GROUP) && group_wait))) // [R15]
		begin
			timer <= trig_seq_pkg::IRQ_COUNT;
		end
		else if (timer != 11'h000)
		begin
			timer <= timer - 11'h001;
		end
	end

	// Interrupt flag: raised when the delay runs out, cleared by writing one to status
	// bit 0; a raise in the clearing cycle wins.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq <= 1'b0;
		end
		else if (timer == 11'h001)
		begin
			irq <= 1'b1;   // [R13] [R15]
		end
		else if (irq_clear)
		begin
			irq <= 1'b0;
		end
	end

	// Checks on the sequencer's own outputs and internal pointer, half and timer.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence fall_armed_s;
		strobe_fall && mode_active && (state != trig_seq_pkg::ST_IDLE);
	endsequence

	strobe_starts_a: assert property (fall_armed_s |=> conv_start) // [R1]
		else $error("strobe edge did not start a conversion");
	start_only_strobe_a: assert property (conv_start |-> $past(strobe_fall)) // [R10]
		else $error("conversion started without a strobe edge");
	no_idle_conv_a: assert property ((state == trig_seq_pkg::ST_IDLE) && strobe_fall |=> !conv_start) // [R20]
		else $error("conversion started while not armed");
	prime_no_write_a: assert property ((state == trig_seq_pkg::ST_PRIME) && step |=> !mb_wr.we) // [R8]
		else $error("first strobe wrote the mailbox");
	run_write_a: assert property ((state == trig_seq_pkg::ST_RUN) && step |=> mb_wr.we && conv_start) // [R6]
		else $error("running strobe did not write the mailbox");
	wrap_ptr_a: assert property (step && (ptr == end_ch) && !arm_write |=> ptr == $past(start_ch)) // [R19]
		else $error("pointer did not wrap to start channel");
	half_range_a: assert property (mb_wr.we |-> (mb_wr.addr >= trig_seq_pkg::MB_BASE_LO)) // [R12]
		else $error("mailbox address below first half");
	irq_delay_a: assert property ($rose(irq) |-> $past(timer) == 11'h001) // [R13]
		else $error("interrupt raised without the full delay");
	timer_load_a: assert property (step && (state == trig_seq_pkg::ST_RUN)
		&& (ctrl.int_mode == trig_seq_pkg::INT_CHANNEL) |=> timer == trig_seq_pkg::IRQ_COUNT) // [R14]
		else $error("channel strobe did not load the interrupt delay");
	half_toggle_a: assert property (step && (ptr == end_ch) && ctrl.diff && !arm_write
		|=> half != $past(half)) // [R11]
		else $error("differential pass did not switch halves");

endmodule : trig_seq

//--- test/strobe_source.sv
// Model of the pacing source and of the converter that sits behind the sequencer.
`timescale 1ns/10ps
module strobe_source
(
	input  wire logic        aclk,                // Module clock.
	input  wire logic        conv_start,          // Conversion start pulse.
	input  wire logic [4:0]  conv_channel,        // Channel being converted.
	output logic             conversion_strobe_n, // Trigger pin, active low.
	output logic [15:0]      adc_result           // Result of the last conversion.
);
	// The pin idles high; the converter powers up holding stale data.
	initial
	begin
		conversion_strobe_n = 1'b1;
		adc_result = 16'h5A5A;
	end
	// Each conversion leaves a result tagged with its channel, so lag is visible.
	// A plain process, since the power-up value above also writes this variable.
	always @(posedge aclk)
	begin
		if (conv_start)
			adc_result <= 16'hA500 | {11'h000, conv_channel};
	end
	// One trigger pulse, low and high long enough for the synchroniser.
	task automatic pulse();
		conversion_strobe_n <= 1'b0;
		repeat (4) @(posedge aclk);
		conversion_strobe_n <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask : pulse
	// Settling time of 5 us at 200 MHz before the first pulse of a run.
	task automatic settle();
		repeat (1000) @(posedge aclk);
	endtask : settle
endmodule : strobe_source

//--- test/tb_trig_seq.sv
// Self-checking testbench for the trigger scan sequencer.
`timescale 1ns/10ps
module tb_trig_seq;
	logic                  aclk;       // Module clock.
	logic                  aresetn;    // Reset, active low.
	logic [4:0]            awaddr;     // Write address.
	logic                  awvalid;    // Write address valid.
	logic                  awready;    // Write address ready.
	logic [31:0]           wdata;      // Write data.
	logic [3:0]            wstrb;      // Byte strobes.
	logic                  wvalid;     // Write data valid.
	logic                  wready;     // Write data ready.
	logic [1:0]            bresp;      // Write response.
	logic                  bvalid;     // Write response valid.
	logic                  bready;     // Write response ready.
	logic [4:0]            araddr;     // Read address.
	logic                  arvalid;    // Read address valid.
	logic                  arready;    // Read address ready.
	logic [31:0]           rdata;      // Read data.
	logic [1:0]            rresp;      // Read response.
	logic                  rvalid;     // Read data valid.
	logic                  rready;     // Read data ready.
	logic                  strobe_n;   // Trigger pin.
	logic                  strobe_out; // Trigger output level.
	logic                  strobe_oe;  // Trigger output enable.
	logic [15:0]           adc_result; // Converter result.
	logic                  conv_start; // Conversion start pulse.
	logic [4:0]            conv_channel; // Channel converted.
	trig_seq_pkg::mb_wr_t  mb_wr;      // Mailbox write port.
	logic                  irq;        // Interrupt level.
	int                    n_errors;   // Mismatches seen.
	int                    tests_run;  // Comparisons made.
	int                    cycles;     // Cycles since time zero.
	int                    n_start;    // Start pulses since last clear.
	int                    n_we;       // Mailbox writes since last clear.
	logic [4:0]            cap_ch;     // Channel of the last start.
	logic [6:0]            cap_addr;   // Address of the last mailbox write.
	logic [15:0]           cap_data;   // Data of the last mailbox write.

	trig_seq i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .conversion_strobe_n(strobe_n), .strobe_out(strobe_out),
		.strobe_oe(strobe_oe), .adc_result(adc_result), .conv_start(conv_start),
		.conv_channel(conv_channel), .mb_wr(mb_wr), .irq(irq));

	strobe_source i_src (.aclk(aclk), .conv_start(conv_start), .conv_channel(conv_channel),
		.conversion_strobe_n(strobe_n), .adc_result(adc_result));

	// Free-running 200 MHz clock.
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	// Records starts and mailbox writes; the cycle ceiling cuts a hang short.
	always @(posedge aclk)
	begin
		cycles++;
		if (conv_start === 1'b1)
		begin
			n_start++;
			cap_ch = conv_channel;
		end
		if (mb_wr.we === 1'b1)
		begin
			n_we++;
			cap_addr = mb_wr.addr;
			cap_data = mb_wr.data;
		end
		if (cycles == 60000)
		begin
			n_errors++;
			close_out();
		end
	end

	// One comparison; case inequality so an unknown never matches.
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// AXI4-Lite write: address and data offered together, each released when taken.
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Only the bench's cycle ceiling ends this wait.
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		check("bresp", {30'h0, er}, {30'h0, bresp});
		// One edge passes so a following call never re-raises bready in this time step.
		@(posedge aclk);
	endtask : axi_wr

	// AXI4-Lite read with expected data and response.
	task automatic axi_rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		// Only the bench's cycle ceiling ends this wait.
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		check("rdata", ed, rdata);
		check("rresp", {30'h0, er}, {30'h0, rresp});
		// One edge passes so a following call never re-raises rready in this time step.
		@(posedge aclk);
	endtask : axi_rd

	// One armed run of n strobes over channels 2 to 4; the first strobe only primes.
	task automatic scan(input logic [31:0] ctrl, input int n);
		int         prev;
		logic [6:0] half;
		axi_wr(trig_seq_pkg::ADDR_CTRL, 32'h0, 2'h0);
		axi_wr(trig_seq_pkg::ADDR_CTRL, ctrl, 2'h0);
		check("strobe_oe input", 0, strobe_oe);
		n_start = 0;
		i_src.pulse();
		repeat (4) @(posedge aclk);
		check("unarmed starts", 0, n_start);
		axi_wr(trig_seq_pkg::ADDR_ARM, 32'h1, 2'h0);
		axi_rd(trig_seq_pkg::ADDR_ARM, 32'h1, 2'h0);
		// Armed and priming, pointer parked on the start channel.
		axi_rd(trig_seq_pkg::ADDR_STATUS, 32'h0000_0202, 2'h0);
		i_src.settle();
		check("arm starts", 0, n_start);
		for (int i = 0; i < n; i++)
		begin
			// Previous channel and the pass it belonged to decide the mailbox slot.
			prev = 2 + (i + 2) % 3;
			half = (ctrl[11] && ((i - 1) / 3) % 2 == 1) ? 7'h20 : 7'h00;
			n_start = 0;
			n_we = 0;
			i_src.pulse();
			repeat (4) @(posedge aclk);
			check("starts", 1, n_start);
			check("channel", 2 + i % 3, cap_ch);
			check("writes", i > 0, n_we);
			if (i > 0)
			begin
				check("mb addr", trig_seq_pkg::MB_BASE_LO + half + 7'(2 * prev), cap_addr);
				check("mb data", 16'hA500 + prev, cap_data);
			end
			repeat (1500) @(posedge aclk);
			check("irq early", 0, irq);
			repeat (200) @(posedge aclk);
			check("irq", ctrl[12] ? i > 0 : (i > 0 && prev == 4), irq);
			if (irq === 1'b1)
				axi_wr(trig_seq_pkg::ADDR_STATUS, 32'h1, 2'h0);
		end
	endtask : scan

	// Main sequence: reset, register map, then two scans.
	initial
	begin
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		n_start = 0;
		n_we = 0;
		aresetn = 1'b0;
		awaddr = 5'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hF;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 5'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(trig_seq_pkg::ADDR_CTRL, 32'h0, 2'h0);
		axi_rd(trig_seq_pkg::ADDR_STATUS, 32'h0, 2'h0);
		axi_rd(5'h14, 32'h0, trig_seq_pkg::RESP_SLVERR);
		axi_wr(5'h14, 32'hFFFFFFFF, trig_seq_pkg::RESP_SLVERR);
		axi_wr(trig_seq_pkg::ADDR_CTRL, 32'h4, 2'h0);
		axi_rd(trig_seq_pkg::ADDR_CTRL, 32'h4, 2'h0);
		repeat (2) @(posedge aclk);
		check("strobe_oe", 1, strobe_oe);
		check("strobe_out", 1, strobe_out);
		axi_wr(trig_seq_pkg::ADDR_START, 32'h2, 2'h0);
		axi_wr(trig_seq_pkg::ADDR_END, 32'h4, 2'h0);
		axi_rd(trig_seq_pkg::ADDR_START, 32'h2, 2'h0);
		axi_rd(trig_seq_pkg::ADDR_END, 32'h4, 2'h0);
		// Single-ended with channel interrupts, then differential with group interrupts.
		scan(32'h1500, 5);
		scan(32'h2D00, 8);
		close_out();
	end
endmodule : tb_trig_seq
